// *** rtl/lichg_pkg.sv ***
// package: constants and state encoding for the charge sequencer
package lichg_pkg;

	// ********************************************************
	// apb register map (byte addresses)
	// ********************************************************
	localparam logic [11:0] CTRL_OFS    = 12'h000;
	localparam logic [11:0] STATUS_OFS  = 12'h004;
	localparam logic [11:0] COMP_OFS    = 12'h008;
	localparam logic [11:0] CURCMD_OFS  = 12'h00c;

	// ********************************************************
	// reset values and field positions
	// ********************************************************
	localparam logic [1:0]  CTRL_RST        = 2'h0;
	localparam int          CTRL_TEMP_IGN   = 0;
	localparam int          CTRL_FORCE_OFF  = 1;

	// ********************************************************
	// charge current commands in percent of full scale
	// ********************************************************
	localparam logic [7:0]  CUR_TRICKLE_PCT = 8'h0f;
	localparam logic [7:0]  CUR_FULL_PCT    = 8'h64;
	localparam logic [7:0]  CUR_OFF_PCT     = 8'h00;

	// ********************************************************
	// analog references, millivolts, carried to status and current command registers
	// ********************************************************
	localparam logic [15:0] VREG_MV         = 16'h3138;
	localparam logic [15:0] VSENSE_REF_MV   = 16'h00c8;

	// comparator synchroniser depth
	localparam int          SYNC_STAGES     = 2;

	// ********************************************************
	// charge states
	// ********************************************************
	typedef enum logic [2:0] {
		ST_SLEEP   = 3'b000,
		ST_TRICKLE = 3'b001,
		ST_CC      = 3'b010,
		ST_CV      = 3'b011,
		ST_DONE    = 3'b100,
		ST_TSUSP   = 3'b101,
		ST_OVHOLD  = 3'b110
	} lichg_state_t;

endpackage

// *** rtl/lichg_seq.sv ***
// module: charge sequencer state machine with apb status and control
// ****************************************************************
// Overview of operation
// - start only above lockout with release margin
// - low battery start enters trickle at 15%
// - battery above 8.4V moves to constant current
// - constant current regulates sense to 200mV
// - near target switch to constant voltage
// - constant voltage holds 12.6V target
// - end-of-charge current terminates, gate drive off
// - charging indicator low only while charging
// - done indicator low only when terminated
// - input power cycle restarts from the beginning
// - terminated battery below 12V restarts charging
// - input absent means sleep, no charging
// - below lockout keeps charger off
// - thermistor out of window suspends charging
// - back in window resumes interrupted cycle
// - overvoltage above 8% holds switch off
// - indicators released on lockout, sleep, temperature
// ****************************************************************
`timescale 1ns/100ps

module lichg_seq (
	input  wire logic        pclk,            // 250 mhz system clock
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	input  wire logic        cmp_above_lockout, // input above lockout level
	input  wire logic        cmp_release,     // input exceeds battery by release margin
	input  wire logic        cmp_input_present, // input supply present above battery
	input  wire logic        cmp_above_precharge, // battery above 8.4v
	input  wire logic        cmp_near_reg,    // battery near 12.6v target
	input  wire logic        cmp_eoc,         // current at end-of-charge level
	input  wire logic        cmp_below_recharge, // battery below 12v
	input  wire logic        cmp_temp_hot,    // thermistor below 175mv
	input  wire logic        cmp_temp_cold,   // thermistor above 1.61v
	input  wire logic        cmp_overvolt,    // battery over trip level
	output logic             switch_gate_drive, // high enables pwm gate drive
	output logic      [7:0]  cur_cmd_pct,     // current command, percent
	output logic             cv_mode,         // voltage loop selected
	output logic             charging_indicator_n_o,  // drives pin low
	output logic             charging_indicator_n_oe, // enable, high drives
	output logic             done_indicator_n_o,      // drives pin low
	output logic             done_indicator_n_oe      // enable, high drives
);

	// ********************************************************
	// comparator synchronisers
	// ********************************************************
	localparam int NCMP = 10;                     // number of comparator inputs
	logic [NCMP-1:0] cmp_raw;                     // raw comparator vector
	wire  [NCMP-1:0] cmp_sync;                    // synchronised comparators

	assign cmp_raw = {cmp_overvolt, cmp_temp_cold, cmp_temp_hot, cmp_below_recharge,
		cmp_eoc, cmp_near_reg, cmp_above_precharge, cmp_input_present,
		cmp_release, cmp_above_lockout};

	// two flop sync per comparator; each bit owns its flops, so no
	// vector is written from more than one process
	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++) begin : g_sync
			logic stage1_ff;                      // first stage, read by stage two only
			logic stage2_ff;                      // second stage, safe to decode
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage1_ff <= 1'b0;
					stage2_ff <= 1'b0;
				end else begin
					stage1_ff <= cmp_raw[gi];
					stage2_ff <= stage1_ff;
				end
			end
			assign cmp_sync[gi] = stage2_ff;
		end
	endgenerate

	// named synchronised levels
	wire s_lock    = cmp_sync[0];
	wire s_rel     = cmp_sync[1];
	wire s_inp     = cmp_sync[2];
	wire s_pre     = cmp_sync[3];
	wire s_near    = cmp_sync[4];
	wire s_eoc     = cmp_sync[5];
	wire s_rech    = cmp_sync[6];
	wire s_hot     = cmp_sync[7];
	wire s_cold    = cmp_sync[8];
	wire s_ov      = cmp_sync[9];

	// ********************************************************
	// control register
	// ********************************************************
	// force off and temperature ignore are bring-up aids for software
	logic [1:0] ctrl_ff;                          // software control bits
	wire        temp_ign  = ctrl_ff[lichg_pkg::CTRL_TEMP_IGN];
	wire        force_off = ctrl_ff[lichg_pkg::CTRL_FORCE_OFF];

	// ********************************************************
	// qualifying conditions
	// ********************************************************
	wire power_ok  = s_lock & s_inp;
	// release margin gates only the start from sleep; recharge and
	// resume from a suspend do not ask for it
	wire start_ok  = power_ok & s_rel & !force_off;
	wire temp_bad  = (s_hot | s_cold) & !temp_ign;

	// ********************************************************
	// state machine
	// ********************************************************
	lichg_pkg::lichg_state_t state_ff;            // current charge state
	lichg_pkg::lichg_state_t nxt_state;           // next charge state
	lichg_pkg::lichg_state_t resume_ff;           // state to resume after suspend
	lichg_pkg::lichg_state_t nxt_resume;          // next resume state

	// next state decision
	always_comb begin
		nxt_state  = state_ff;
		nxt_resume = resume_ff;
		if (!power_ok || force_off) begin
			nxt_state = lichg_pkg::ST_SLEEP;
		end else begin
			case (state_ff)
				lichg_pkg::ST_SLEEP: begin
					if (start_ok) begin
						nxt_state = s_pre ? lichg_pkg::ST_CC
							: lichg_pkg::ST_TRICKLE;
					end
				end
				lichg_pkg::ST_TRICKLE: begin
					if (s_pre) begin
						nxt_state = lichg_pkg::ST_CC;
					end
				end
				lichg_pkg::ST_CC: begin
					if (s_near) begin
						nxt_state = lichg_pkg::ST_CV;
					end
				end
				lichg_pkg::ST_CV: begin
					if (s_eoc) begin
						nxt_state = lichg_pkg::ST_DONE;
					end
				end
				lichg_pkg::ST_DONE: begin
					if (s_rech) begin
						nxt_state = s_pre ? lichg_pkg::ST_CC
							: lichg_pkg::ST_TRICKLE;
					end
				end
				lichg_pkg::ST_TSUSP: begin
					if (!temp_bad) begin
						nxt_state = resume_ff;
					end
				end
				lichg_pkg::ST_OVHOLD: begin
					if (!s_ov) begin
						nxt_state = resume_ff;
					end
				end
				default: begin
					nxt_state = lichg_pkg::ST_SLEEP;
				end
			endcase
			// suspend and overvoltage override active charge states
			if (nxt_state == lichg_pkg::ST_TRICKLE || nxt_state == lichg_pkg::ST_CC
				|| nxt_state == lichg_pkg::ST_CV) begin
				if (s_ov) begin
					nxt_resume = nxt_state;
					nxt_state  = lichg_pkg::ST_OVHOLD;
				end else if (temp_bad) begin
					nxt_resume = nxt_state;
					nxt_state  = lichg_pkg::ST_TSUSP;
				end
			end else if (state_ff == lichg_pkg::ST_TSUSP && s_ov) begin
				nxt_state = lichg_pkg::ST_OVHOLD;
			end else if (state_ff == lichg_pkg::ST_OVHOLD && !s_ov && temp_bad) begin
				nxt_state = lichg_pkg::ST_TSUSP;
			end
		end
	end

	// state registers, one encoded state only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= lichg_pkg::ST_SLEEP;
			resume_ff <= lichg_pkg::ST_TRICKLE;
		end else begin
			state_ff  <= nxt_state;
			resume_ff <= nxt_resume;
		end
	end

	// ********************************************************
	// output decode
	// ********************************************************
	// outputs decode the next state, so pins and state register change
	// on the same edge with no extra cycle of lag
	wire is_chg  = (nxt_state == lichg_pkg::ST_TRICKLE) || (nxt_state == lichg_pkg::ST_CC)
		|| (nxt_state == lichg_pkg::ST_CV);
	// a pack out of its temperature window releases the done pin as well
	wire is_done = (nxt_state == lichg_pkg::ST_DONE) && !temp_bad;
	wire [7:0] nxt_cur = (nxt_state == lichg_pkg::ST_TRICKLE) ? lichg_pkg::CUR_TRICKLE_PCT
		: is_chg ? lichg_pkg::CUR_FULL_PCT : lichg_pkg::CUR_OFF_PCT;

	// registered pin and loop outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_gate_drive       <= 1'b0;
			cur_cmd_pct             <= 8'h00;
			cv_mode                 <= 1'b0;
			charging_indicator_n_oe <= 1'b0;
			done_indicator_n_oe     <= 1'b0;
		end else begin
			switch_gate_drive       <= is_chg;
			cur_cmd_pct             <= nxt_cur;
			cv_mode                 <= (nxt_state == lichg_pkg::ST_CV);
			charging_indicator_n_oe <= is_chg;
			done_indicator_n_oe     <= is_done;
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charging_indicator_n_o <= 1'b0;
			done_indicator_n_o     <= 1'b0;
		end else begin
			charging_indicator_n_o <= 1'b0;
			done_indicator_n_o     <= 1'b0;
		end
	end

	// ********************************************************
	// apb slave, zero wait states
	// ********************************************************
	wire acc      = psel & penable;
	wire hit_ctrl = (paddr == lichg_pkg::CTRL_OFS);
	wire hit_stat = (paddr == lichg_pkg::STATUS_OFS);
	wire hit_comp = (paddr == lichg_pkg::COMP_OFS);
	wire hit_cur  = (paddr == lichg_pkg::CURCMD_OFS);
	wire hit_any  = hit_ctrl | hit_stat | hit_comp | hit_cur;
	wire [31:0] rd_mux;

	// read data select
	assign rd_mux = hit_ctrl ? {30'h0, ctrl_ff}
		: hit_stat ? {13'h0, state_ff, lichg_pkg::VREG_MV}
		: hit_comp ? {22'h0, cmp_sync}
		: hit_cur  ? {8'h0, lichg_pkg::VSENSE_REF_MV, cur_cmd_pct}
		: 32'h0;

	// control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= lichg_pkg::CTRL_RST;
		end else if (acc && pwrite && hit_ctrl) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	// read data and answer flops; pready rises the cycle after setup,
	// so every access phase lasts exactly one cycle and prdata,
	// captured at setup, stands through it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_state_legal: assert property (state_ff != 3'b111)
		else $error("illegal charge state");
	a_gate_off_done: assert property (state_ff == lichg_pkg::ST_DONE |-> !switch_gate_drive)
		else $error("gate on while terminated");
	a_gate_off_ov: assert property ($rose(s_ov) |-> ##1 !switch_gate_drive)
		else $error("gate on during overvoltage");
	a_temp_suspend: assert property (s_hot && !temp_ign && is_chg |-> 0)
		else $error("charging while hot");
	a_trickle_cur: assert property (state_ff == lichg_pkg::ST_TRICKLE && $stable(state_ff)
		|-> cur_cmd_pct == 8'h0f)
		else $error("trickle current wrong");
	a_sleep_power: assert property (!power_ok |=> state_ff == lichg_pkg::ST_SLEEP)
		else $error("not asleep without power");
	a_ind_excl: assert property (!(charging_indicator_n_oe && done_indicator_n_oe))
		else $error("both indicators low");
	a_done_ind: assert property (state_ff == lichg_pkg::ST_DONE && !$past(temp_bad)
		|-> done_indicator_n_oe)
		else $error("done indicator off");
	a_recharge: assert property (state_ff == lichg_pkg::ST_DONE && s_rech && power_ok
		&& !force_off && !s_ov && !temp_bad |=> is_chg || state_ff != lichg_pkg::ST_DONE)
		else $error("no recharge");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready not a pulse");

	// ****************************************************************
	// sequencing checks
	// ****************************************************************
	// each check names every condition that may override the step it
	// guards, so a legal priority never looks like a failure
	a_start_margin: assert property (state_ff == lichg_pkg::ST_SLEEP && !start_ok
		|=> state_ff == lichg_pkg::ST_SLEEP)
		else $error("start without release margin");
	a_trickle_entry: assert property (state_ff == lichg_pkg::ST_SLEEP && start_ok
		&& !s_pre && !s_ov && !temp_bad |=> state_ff == lichg_pkg::ST_TRICKLE)
		else $error("low battery start missed trickle");
	a_cc_entry: assert property (state_ff == lichg_pkg::ST_TRICKLE && s_pre && power_ok
		&& !force_off && !s_ov && !temp_bad |=> state_ff == lichg_pkg::ST_CC)
		else $error("trickle did not end above threshold");
	a_cv_entry: assert property (state_ff == lichg_pkg::ST_CC && s_near && power_ok
		&& !force_off && !s_ov && !temp_bad |=> state_ff == lichg_pkg::ST_CV)
		else $error("no hand over to voltage loop");
	a_eoc_done: assert property (state_ff == lichg_pkg::ST_CV && s_eoc && power_ok
		&& !force_off |=> state_ff == lichg_pkg::ST_DONE)
		else $error("no termination at end of charge");
	a_temp_resume: assert property (state_ff == lichg_pkg::ST_TSUSP && !temp_bad
		&& !s_ov && power_ok && !force_off |=> state_ff == $past(resume_ff))
		else $error("suspend did not resume");
	a_ov_resume: assert property (state_ff == lichg_pkg::ST_OVHOLD && !s_ov
		&& !temp_bad && power_ok && !force_off |=> state_ff == $past(resume_ff))
		else $error("overvoltage hold did not resume");
	a_lockout_off: assert property (!s_lock |=> !switch_gate_drive)
		else $error("gate on below lockout");

	// ****************************************************************
	// output checks
	// ****************************************************************
	// full scale current in CC and CV, loop and charging outputs agree with the state register every cycle; both indicators release on bad temperature
	a_cc_current: assert property (state_ff == lichg_pkg::ST_CC
		|| state_ff == lichg_pkg::ST_CV |-> cur_cmd_pct == lichg_pkg::CUR_FULL_PCT)
		else $error("full scale current wrong");
	a_cv_flag: assert property (cv_mode == (state_ff == lichg_pkg::ST_CV))
		else $error("voltage loop flag wrong");
	a_chg_ind: assert property (charging_indicator_n_oe == (state_ff == lichg_pkg::ST_TRICKLE
		|| state_ff == lichg_pkg::ST_CC || state_ff == lichg_pkg::ST_CV))
		else $error("charging indicator wrong");
	a_temp_release: assert property (temp_bad |=> !charging_indicator_n_oe && !done_indicator_n_oe)
		else $error("indicator held while out of temperature");

	// ****************************************************************
	// cover points
	// ****************************************************************
	// main paths through the charge sequence
	c_full_cycle: cover property (state_ff == lichg_pkg::ST_CV ##1 state_ff == lichg_pkg::ST_DONE);
	c_recharge: cover property (state_ff == lichg_pkg::ST_DONE ##1 state_ff == lichg_pkg::ST_CC);
	c_temp_resume: cover property (state_ff == lichg_pkg::ST_TSUSP ##1 state_ff == lichg_pkg::ST_CC);
	c_ov_hold: cover property (state_ff == lichg_pkg::ST_OVHOLD);
	c_trickle_start: cover property (state_ff == lichg_pkg::ST_SLEEP ##1 state_ff == lichg_pkg::ST_TRICKLE);

endmodule

// *** verification/lichg_batt_model.sv ***
// file: far-side model of supply, battery, thermistor and indicator pins
`timescale 1ns/100ps

module lichg_batt_model #(
	parameter int REL_MV  = 420,   // sleep release margin, mv
	parameter int NEAR_MV = 12400, // battery level that hands over to voltage loop
	parameter int EOC_MA  = 200    // end-of-charge current, ma
) (
	input  wire logic [15:0] vcc_mv,
	input  wire logic [15:0] vbat_mv,
	input  wire logic [15:0] temp_mv,
	input  wire logic [15:0] ichg_ma,
	input  wire logic        chg_o,
	input  wire logic        chg_oe,
	input  wire logic        done_o,
	input  wire logic        done_oe,
	output logic             cmp_above_lockout,
	output logic             cmp_release,
	output logic             cmp_input_present,
	output logic             cmp_above_precharge,
	output logic             cmp_near_reg,
	output logic             cmp_eoc,
	output logic             cmp_below_recharge,
	output logic             cmp_temp_hot,
	output logic             cmp_temp_cold,
	output logic             cmp_overvolt,
	output logic             chg_pin,
	output logic             done_pin
);
	// ****************************************************
	// analog comparators seen from the pins
	// ****************************************************
	assign cmp_above_lockout   = vcc_mv > 16'h1770;
	assign cmp_release         = int'(vcc_mv) - int'(vbat_mv) > REL_MV;
	assign cmp_input_present   = vcc_mv > vbat_mv;
	assign cmp_above_precharge = vbat_mv > 16'h20d0;
	assign cmp_near_reg        = int'(vbat_mv) >= NEAR_MV;
	assign cmp_eoc             = int'(ichg_ma) <= EOC_MA;
	assign cmp_below_recharge  = vbat_mv < 16'h2ee0;
	assign cmp_temp_hot        = temp_mv < 16'h00af;
	assign cmp_temp_cold       = temp_mv > 16'h064a;
	assign cmp_overvolt        = vbat_mv > 16'h3528;
	// ****************************************************
	// led pull-ups: a released pin reads high
	// ****************************************************
	assign chg_pin  = chg_oe ? chg_o : 1'b1;
	assign done_pin = done_oe ? done_o : 1'b1;
endmodule

// *** verification/liion_charge_sequencer_tb_top.sv ***
// file: self-checking testbench of the charge sequencer
`timescale 1ns/100ps

module liion_charge_sequencer_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gate, cvm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  cur;
	logic        ca, cr, cp, cpre, cn, ce, cb, ch, cc, cov, co, coe, dn, doe, chp, dnp;
	logic [15:0] vcc, vbat, tmp, ich;
	logic        err;
	int          miscompares, comparisons;

	lichg_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_above_lockout(ca), .cmp_release(cr), .cmp_input_present(cp),
		.cmp_above_precharge(cpre), .cmp_near_reg(cn), .cmp_eoc(ce), .cmp_below_recharge(cb),
		.cmp_temp_hot(ch), .cmp_temp_cold(cc), .cmp_overvolt(cov), .switch_gate_drive(gate),
		.cur_cmd_pct(cur), .cv_mode(cvm), .charging_indicator_n_o(co),
		.charging_indicator_n_oe(coe), .done_indicator_n_o(dn), .done_indicator_n_oe(doe));

	lichg_batt_model model_u (.vcc_mv(vcc), .vbat_mv(vbat), .temp_mv(tmp), .ichg_ma(ich),
		.chg_o(co), .chg_oe(coe), .done_o(dn), .done_oe(doe), .cmp_above_lockout(ca),
		.cmp_release(cr), .cmp_input_present(cp), .cmp_above_precharge(cpre),
		.cmp_near_reg(cn), .cmp_eoc(ce), .cmp_below_recharge(cb), .cmp_temp_hot(ch),
		.cmp_temp_cold(cc), .cmp_overvolt(cov), .chg_pin(chp), .done_pin(dnp));

	// ****************************************************
	// clock and watchdog
	// ****************************************************
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		#200000;
		miscompares++;
		conclude();
	end

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic conclude();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// new analog conditions, then let the synchronisers settle
	task automatic env(input int v, input int b, input int t, input int i);
		vcc <= 16'(v);
		vbat <= 16'(b);
		tmp <= 16'(t);
		ich <= 16'(i);
		repeat (5) @(posedge pclk);
	endtask

	// state, gate, current command and both indicator pin levels
	task automatic expect_st(input logic [2:0] s, input logic g, input logic [7:0] c,
		input logic cpin, input logic dpin);
		apb(1'b0, lichg_pkg::STATUS_OFS, 32'h0);
		chk({29'h0, q[18:16]}, {29'h0, s});
		chk({31'h0, gate}, {31'h0, g});
		chk({24'h0, cur}, {24'h0, c});
		chk({30'h0, chp, dnp}, {30'h0, cpin, dpin});
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		vcc = 16'h1388;
		vbat = 16'h1f40;
		tmp = 16'h01f4;
		ich = 16'h03e8;
		miscompares = 0;
		comparisons = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, lichg_pkg::STATUS_OFS, 32'h0);
		chk(q, 32'h0000_3138);
		apb(1'b0, lichg_pkg::CURCMD_OFS, 32'h0);
		chk(q, 32'h0000_c800);
		apb(1'b1, 12'h010, 32'h0000_0003);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, lichg_pkg::CTRL_OFS, 32'h0);
		chk(q, 32'h0);
		env(5000, 8000, 500, 1000);
		expect_st(3'h0, 1'b0, 8'h00, 1'b1, 1'b1);
		env(8100, 8000, 500, 1000);
		expect_st(3'h0, 1'b0, 8'h00, 1'b1, 1'b1);
		env(15000, 8000, 500, 1000);
		expect_st(3'h1, 1'b1, 8'h0f, 1'b0, 1'b1);
		env(15000, 9000, 500, 1000);
		expect_st(3'h2, 1'b1, 8'h64, 1'b0, 1'b1);
		env(15000, 9000, 100, 1000);
		expect_st(3'h5, 1'b0, 8'h00, 1'b1, 1'b1);
		env(15000, 9000, 500, 1000);
		expect_st(3'h2, 1'b1, 8'h64, 1'b0, 1'b1);
		env(15000, 9000, 2000, 1000);
		expect_st(3'h5, 1'b0, 8'h00, 1'b1, 1'b1);
		env(15000, 9000, 500, 1000);
		// two terminate and recharge rounds toggle both indicator pins
		repeat (2) begin
			env(15000, 12500, 500, 1000);
			expect_st(3'h3, 1'b1, 8'h64, 1'b0, 1'b1);
			chk({31'h0, cvm}, 32'h1);
			env(15000, 12500, 500, 100);
			expect_st(3'h4, 1'b0, 8'h00, 1'b1, 1'b0);
			env(15000, 12500, 100, 100);
			expect_st(3'h4, 1'b0, 8'h00, 1'b1, 1'b1);
			env(15000, 11900, 500, 1000);
			expect_st(3'h2, 1'b1, 8'h64, 1'b0, 1'b1);
		end
		env(15000, 13700, 500, 1000);
		expect_st(3'h6, 1'b0, 8'h00, 1'b1, 1'b1);
		// the hold was entered on the step into voltage mode, which resumes
		env(15000, 9000, 500, 1000);
		expect_st(3'h3, 1'b1, 8'h64, 1'b0, 1'b1);
		chk({31'h0, cvm}, 32'h1);
		env(0, 9000, 500, 1000);
		expect_st(3'h0, 1'b0, 8'h00, 1'b1, 1'b1);
		env(15000, 8000, 500, 1000);
		expect_st(3'h1, 1'b1, 8'h0f, 1'b0, 1'b1);
		// software force off, then temperature ignore with a hot pack
		apb(1'b1, lichg_pkg::CTRL_OFS, 32'h0000_0002);
		env(15000, 8000, 500, 1000);
		expect_st(3'h0, 1'b0, 8'h00, 1'b1, 1'b1);
		apb(1'b0, lichg_pkg::CTRL_OFS, 32'h0);
		chk(q, 32'h0000_0002);
		apb(1'b1, lichg_pkg::CTRL_OFS, 32'h0000_0001);
		env(15000, 9000, 100, 1000);
		expect_st(3'h2, 1'b1, 8'h64, 1'b0, 1'b1);
		apb(1'b0, lichg_pkg::COMP_OFS, 32'h0);
		chk(q, 32'h0000_00cf);
		conclude();
	end
endmodule
